//--- core/program_sequencer.sv
// program sequencer: phases, pc, return stack, alu, table reads, apb registers
// assumes program memory on the same clock, data valid within one instruction cycle
// assumes interrupt request logic on the same clock
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
module program_sequencer
	import program_sequencer_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input  wire logic                        CLK,
	input  wire logic                        SYS_RST,
	// register bus
	input  wire program_sequencer_pkg::apb_req_t APB_REQ,
	output      program_sequencer_pkg::apb_rsp_t APB_RSP,
	// program memory
	output      program_sequencer_pkg::pc_t      PM_ADDR,
	input  wire program_sequencer_pkg::word_t    PM_RDATA,
	// interrupt logic
	input  wire logic                        INT_REQ,
	output      logic                        INT_ACK,
	// status
	output      program_sequencer_pkg::phase_t   CYCLE_PHASES
);
	import program_sequencer_pkg::*;

	// depth must be a power of two so the write pointer wraps onto the oldest entry
	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam logic [SP_W:0] DEPTH_CNT = (SP_W+1)'(STACK_DEPTH);

	phase_t          phase_ff;
	pc_t             pc_ff;
	word_t           ir_ff;
	logic            ir_valid_ff;
	logic            tbl_ff;
	logic            tbl_last_ff;
	logic [7:0]      acc_ff;
	logic [3:0]      flags_ff;
	logic [7:0]      tbl_lo_ff;
	logic [2:0]      tbl_hi_ff;
	logic [7:0]      tbl_latch_ff;
	logic [1:0]      ctrl_ff;
	logic            irq_flag_ff;
	logic            pcl_pend_ff;
	logic [7:0]      pcl_val_ff;
	logic [31:0]     rdata_ff;
	logic            ack_ff;
	pc_t             stack_mem [STACK_DEPTH];
	logic [SP_W-1:0] wp_ff;
	logic [SP_W:0]   cnt_ff;

	// decode
	wire opcode_t    op       = opcode_t'(ir_ff[15:12]);
	wire alu_op_t    aop      = alu_op_t'(ir_ff[11:8]);
	wire logic [7:0] imm      = ir_ff[7:0];
	wire pc_t        target   = ir_ff[PC_W-1:0];
	wire logic       run      = ctrl_ff[CTRL_RUN_BIT];
	wire logic       int_en   = ctrl_ff[CTRL_IE_BIT];
	wire pc_t        pc_inc   = pc_ff + 11'h001;
	wire logic       stk_full = (cnt_ff == DEPTH_CNT);
	wire logic       stk_empty = (cnt_ff == '0);
	wire logic [SP_W-1:0] wp_dec = wp_ff - SP_W'(1);
	wire pc_t        stk_top  = stack_mem[wp_dec];

	wire logic step      = (phase_ff == PH_WRITE) && run;
	wire logic do_tbl    = step && tbl_ff;
	wire logic do_pcl    = step && !tbl_ff && pcl_pend_ff;
	wire logic do_ack    = step && !tbl_ff && !pcl_pend_ff && ir_valid_ff
		&& irq_flag_ff && int_en && !stk_full;
	wire logic do_exec   = step && !tbl_ff && !pcl_pend_ff && !do_ack && ir_valid_ff;
	wire logic is_op     = do_exec;
	wire logic skip_hit  = is_op && (op == OP_SKIP) && ((acc_ff == 8'h00) ^ ir_ff[0]);
	wire logic is_branch = is_op && (op == OP_JMP || op == OP_CALL || op == OP_RET
		|| op == OP_INTERRUPT_RETURN || op == OP_SETPCL);
	wire logic is_trd    = is_op && (op == OP_TRDC || op == OP_TRDL);
	wire logic push      = do_ack || (is_op && op == OP_CALL);
	wire logic pop       = is_op && (op == OP_RET || op == OP_INTERRUPT_RETURN);

	wire pc_t tbl_addr = {tbl_last_ff ? 3'b111 : tbl_hi_ff, tbl_lo_ff};
	assign PM_ADDR      = tbl_ff ? tbl_addr : pc_ff;
	assign CYCLE_PHASES = phase_ff;
	assign INT_ACK      = ack_ff;

	// alu
	logic [7:0] bb;
	logic       cin;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [7:0] adj;
	logic [8:0] daa9;
	logic [7:0] alu_res;
	logic [3:0] alu_flags;

	always_comb begin
		bb  = imm;
		cin = 1'b0;
		case (aop)
			ALU_ADC: cin = flags_ff[FLAG_C_BIT];
			ALU_SUB: begin
				bb  = ~imm;
				cin = 1'b1;
			end
			ALU_SBC: begin
				bb  = ~imm;
				cin = flags_ff[FLAG_C_BIT];
			end
			default: cin = 1'b0;
		endcase
	end

	assign sum9 = {1'b0, acc_ff} + {1'b0, bb} + {8'h00, cin};
	assign nib5 = {1'b0, acc_ff[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
	assign adj[3:0] = (acc_ff[3:0] > 4'h9 || flags_ff[FLAG_AC_BIT]) ? 4'h6 : 4'h0;
	assign adj[7:4] = (acc_ff[7:4] > 4'h9 || flags_ff[FLAG_C_BIT]
		|| (acc_ff[7:4] == 4'h9 && acc_ff[3:0] > 4'h9)) ? 4'h6 : 4'h0;
	assign daa9 = {1'b0, acc_ff} + {1'b0, adj};

	always_comb begin
		alu_res   = acc_ff;
		alu_flags = flags_ff;
		case (aop)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
				alu_res                = sum9[7:0];
				alu_flags[FLAG_C_BIT]  = sum9[8];
				alu_flags[FLAG_AC_BIT] = nib5[4];
				alu_flags[FLAG_OV_BIT] = (acc_ff[7] == bb[7]) && (sum9[7] != acc_ff[7]);
			end
			ALU_DAA: begin
				alu_res               = daa9[7:0];
				alu_flags[FLAG_C_BIT] = daa9[8] | flags_ff[FLAG_C_BIT];
			end
			ALU_AND: alu_res = acc_ff & imm;
			ALU_OR:  alu_res = acc_ff | imm;
			ALU_XOR: alu_res = acc_ff ^ imm;
			ALU_CPL: alu_res = ~acc_ff;
			ALU_RR:  alu_res = {acc_ff[0], acc_ff[7:1]};
			ALU_RL:  alu_res = {acc_ff[6:0], acc_ff[7]};
			ALU_RRC: begin
				alu_res               = {flags_ff[FLAG_C_BIT], acc_ff[7:1]};
				alu_flags[FLAG_C_BIT] = acc_ff[0];
			end
			ALU_RLC: begin
				alu_res               = {acc_ff[6:0], flags_ff[FLAG_C_BIT]};
				alu_flags[FLAG_C_BIT] = acc_ff[7];
			end
			ALU_INC: alu_res = acc_ff + 8'h01;
			ALU_DEC: alu_res = acc_ff - 8'h01;
			ALU_MOV: alu_res = imm;
			default: alu_res = acc_ff;
		endcase
		// rotates and plain moves leave zero alone
		if (aop != ALU_RR && aop != ALU_RL && aop != ALU_RRC && aop != ALU_RLC
			&& aop != ALU_MOV) begin
			alu_flags[FLAG_Z_BIT] = (alu_res == 8'h00);
		end
	end

	// next pc and pipeline
	pc_t  nxt_pc;
	word_t nxt_ir;
	logic nxt_ir_valid;

	always_comb begin
		nxt_pc       = pc_ff;
		nxt_ir       = ir_ff;
		nxt_ir_valid = ir_valid_ff;
		if (do_tbl) begin
			// table cycle fetched table data, so pc and prefetch hold
			nxt_pc = pc_ff;
		end else if (do_pcl) begin
			nxt_pc       = {pc_ff[PC_W-1:PAGE_W], pcl_val_ff};
			nxt_ir_valid = 1'b0;
		end else if (do_ack) begin
			nxt_pc       = INT_VECTOR;
			nxt_ir_valid = 1'b0;
		end else if (is_branch) begin
			nxt_ir_valid = 1'b0;
			case (op)
				OP_JMP, OP_CALL: nxt_pc = target;
				OP_RET, OP_INTERRUPT_RETURN: nxt_pc = stk_top;
				OP_SETPCL:       nxt_pc = {pc_ff[PC_W-1:PAGE_W], acc_ff};
				default:         nxt_pc = pc_ff;
			endcase
		end else if (skip_hit) begin
			nxt_pc       = pc_inc;
			nxt_ir_valid = 1'b0;
		end else if (step) begin
			nxt_pc       = pc_inc;
			nxt_ir       = PM_RDATA;
			nxt_ir_valid = 1'b1;
		end
	end

	// apb decode
	wire logic setup   = APB_REQ.psel && !APB_REQ.penable;
	wire logic access  = APB_REQ.psel && APB_REQ.penable;
	wire logic hit_pcl = (APB_REQ.paddr == OFS_PCL);
	wire logic hit_ctl = (APB_REQ.paddr == OFS_CTRL);
	wire logic hit_ro  = (APB_REQ.paddr == OFS_TABLE_HIGH_LATCH) || (APB_REQ.paddr == OFS_ACC)
		|| (APB_REQ.paddr == OFS_STATUS) || (APB_REQ.paddr == OFS_TPTR);
	wire logic bad     = !(hit_pcl || hit_ctl || hit_ro) || (APB_REQ.pwrite && hit_ro);
	wire logic wr_pcl  = access && APB_REQ.pwrite && hit_pcl;
	wire logic wr_ctl  = access && APB_REQ.pwrite && hit_ctl;
	wire logic [5:0] status = {tbl_ff, irq_flag_ff, flags_ff};
	wire logic [31:0] rd_mux =
		(APB_REQ.paddr == OFS_PCL)    ? {24'h000000, pc_ff[7:0]} :
		(APB_REQ.paddr == OFS_TABLE_HIGH_LATCH)   ? {24'h000000, tbl_latch_ff} :
		(APB_REQ.paddr == OFS_ACC)    ? {24'h000000, acc_ff} :
		(APB_REQ.paddr == OFS_STATUS) ? {26'h0000000, status} :
		(APB_REQ.paddr == OFS_CTRL)   ? {30'h00000000, ctrl_ff} :
		(APB_REQ.paddr == OFS_TPTR)   ? {21'h000000, tbl_hi_ff, tbl_lo_ff} :
		32'h00000000;

	assign APB_RSP.prdata  = rdata_ff;
	assign APB_RSP.pready  = 1'b1;
	assign APB_RSP.pslverr = access && bad;

	// phase counter and pipeline registers
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			phase_ff    <= PH_FETCH;
			pc_ff       <= RESET_VECTOR;
			ir_ff       <= IR_RESET;
			ir_valid_ff <= 1'b0;
		end else begin
			phase_ff    <= phase_t'(phase_ff + 2'd1);
			pc_ff       <= nxt_pc;
			ir_ff       <= nxt_ir;
			ir_valid_ff <= nxt_ir_valid;
		end
	end

	// data path registers
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			acc_ff       <= ACC_RESET;
			flags_ff     <= FLAGS_RESET;
			tbl_lo_ff    <= 8'h00;
			tbl_hi_ff    <= 3'h0;
			tbl_latch_ff <= 8'h00;
			tbl_ff       <= 1'b0;
			tbl_last_ff  <= 1'b0;
		end else begin
			if (is_op && op == OP_ALU) begin
				acc_ff   <= alu_res;
				flags_ff <= alu_flags;
			end
			if (is_op && op == OP_SETTL) begin
				tbl_lo_ff <= acc_ff;
			end
			if (is_op && op == OP_SETTH) begin
				tbl_hi_ff <= acc_ff[2:0];
			end
			if (is_trd) begin
				tbl_ff      <= 1'b1;
				tbl_last_ff <= (op == OP_TRDL);
			end else if (do_tbl) begin
				tbl_ff <= 1'b0;
			end
			if (do_tbl) begin
				acc_ff       <= PM_RDATA[7:0];
				tbl_latch_ff <= PM_RDATA[15:8];
			end
		end
	end

	// interrupt saves the address of the word it displaced, so that word still runs
	wire pc_t push_val = do_ack ? pc_ff - 11'h001 : pc_ff;

	// return stack
	always_ff @(posedge CLK) begin
		if (push) begin
			stack_mem[wp_ff] <= push_val;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			wp_ff  <= '0;
			cnt_ff <= '0;
		end else if (push) begin
			wp_ff  <= wp_ff + SP_W'(1);
			cnt_ff <= stk_full ? cnt_ff : cnt_ff + (SP_W+1)'(1);
		end else if (pop) begin
			wp_ff  <= wp_dec;
			cnt_ff <= stk_empty ? cnt_ff : cnt_ff - (SP_W+1)'(1);
		end
	end

	// interrupt flag, control and bus registers
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			irq_flag_ff <= 1'b0;
			ctrl_ff     <= CTRL_RESET;
			pcl_pend_ff <= 1'b0;
			pcl_val_ff  <= 8'h00;
			rdata_ff    <= 32'h00000000;
			ack_ff      <= 1'b0;
		end else begin
			irq_flag_ff <= INT_REQ || (irq_flag_ff && !do_ack);
			ack_ff      <= do_ack;
			if (wr_ctl) begin
				ctrl_ff <= APB_REQ.pwdata[1:0];
			end else if (do_ack) begin
				ctrl_ff[CTRL_IE_BIT] <= 1'b0;
			end else if (is_op && op == OP_INTERRUPT_RETURN) begin
				ctrl_ff[CTRL_IE_BIT] <= 1'b1;
			end
			if (wr_pcl) begin
				pcl_pend_ff <= 1'b1;
				pcl_val_ff  <= APB_REQ.pwdata[7:0];
			end else if (do_pcl) begin
				pcl_pend_ff <= 1'b0;
			end
			if (setup) begin
				rdata_ff <= rd_mux;
			end
		end
	end

endmodule

//--- core/program_sequencer_pkg.sv
// constants, types and encodings shared by the program sequencer
// assumes a single 20 MHz system clock and a synchronous active-high reset
package program_sequencer_pkg;

	// clock and cycle structure
	localparam int CLK_PERIOD_NS = 50;
	localparam int PHASE_COUNT   = 4;

	// program memory geometry: 2K words of 16 bits
	localparam int PC_W    = 11;
	localparam int WORD_W  = 16;
	localparam int PAGE_W  = 8;

	typedef logic [PC_W-1:0]   pc_t;
	typedef logic [WORD_W-1:0] word_t;

	// vectors and reset values
	localparam pc_t        RESET_VECTOR = 11'h000;
	localparam pc_t        INT_VECTOR   = 11'h004;
	localparam logic [7:0] ACC_RESET    = 8'h00;
	localparam logic [3:0] FLAGS_RESET  = 4'h0;
	localparam logic [1:0] CTRL_RESET   = 2'h1;
	localparam word_t      IR_RESET     = 16'h0000;

	// register offsets, byte addresses on the bus
	localparam logic [7:0] OFS_PCL    = 8'h00;
	localparam logic [7:0] OFS_TABLE_HIGH_LATCH   = 8'h04;
	localparam logic [7:0] OFS_ACC    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_CTRL   = 8'h10;
	localparam logic [7:0] OFS_TPTR   = 8'h14;

	// control and status field positions
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_IE_BIT   = 1;
	localparam int FLAG_C_BIT    = 0;
	localparam int FLAG_AC_BIT   = 1;
	localparam int FLAG_Z_BIT    = 2;
	localparam int FLAG_OV_BIT   = 3;
	localparam int STAT_IRQ_BIT  = 4;
	localparam int STAT_TBL_BIT  = 5;

	// instruction word: [15:12] opcode, [11:8] alu op, [7:0] immediate, [10:0] target
	typedef enum logic [3:0] {
		OP_NOP, OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN, OP_ALU, OP_SKIP,
		OP_TRDC, OP_TRDL, OP_SETTL, OP_SETTH, OP_SETPCL
	} opcode_t;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
		ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOV
	} alu_op_t;

	typedef enum logic [1:0] {
		PH_FETCH, PH_DECODE, PH_EXEC, PH_WRITE
	} phase_t;

	// apb carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

endpackage

//--- verification/program_sequencer_properties.sv
// port-level checker for the program sequencer
// assumes one clock domain; bound to the top module below
`timescale 1ns/10ps
module program_sequencer_properties
	import program_sequencer_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input wire logic                             CLK,
	input wire logic                             SYS_RST,
	// watched ports
	input wire program_sequencer_pkg::apb_req_t  APB_REQ,
	input wire program_sequencer_pkg::apb_rsp_t  APB_RSP,
	input wire program_sequencer_pkg::pc_t       PM_ADDR,
	input wire program_sequencer_pkg::word_t     PM_RDATA,
	input wire logic                             INT_REQ,
	input wire logic                             INT_ACK,
	input wire program_sequencer_pkg::phase_t    CYCLE_PHASES
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	wire  pcl_wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && APB_REQ.paddr == OFS_PCL;
	pc_t  pcl_exp_ff;
	// page kept from the write cycle
	always_ff @(posedge CLK) begin
		if (pcl_wr) begin
			pcl_exp_ff <= {PM_ADDR[10:8], APB_REQ.pwdata[7:0]};
		end
	end
	sequence s_access;
		APB_REQ.psel && APB_REQ.penable;
	endsequence
	sequence s_pcl_write;
		s_access ##0 (APB_REQ.pwrite && APB_REQ.paddr == OFS_PCL);
	endsequence
	sequence s_ro_write;
		s_access ##0 (APB_REQ.pwrite && APB_REQ.paddr == OFS_TABLE_HIGH_LATCH);
	endsequence
	property p_phase;
		1 |=> CYCLE_PHASES == phase_t'($past(CYCLE_PHASES) + 2'h1);
	endproperty
	a_phase: assert property (p_phase) else $error("phase did not advance by one");
	property p_addr_stable;
		!$past(SYS_RST) && CYCLE_PHASES != PH_FETCH |-> $stable(PM_ADDR);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("fetch address moved");
	property p_reset_vec;
		disable iff (1'b0) SYS_RST |=> PM_ADDR == RESET_VECTOR && CYCLE_PHASES == PH_FETCH && !INT_ACK;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset state wrong");
	property p_pcl_jump;
		s_pcl_write |=> ##[0:8] PM_ADDR == pcl_exp_ff;
	endproperty
	a_pcl_jump: assert property (p_pcl_jump) else $error("low byte jump missing");
	property p_ack_vec;
		$rose(INT_ACK) |-> PM_ADDR == INT_VECTOR;
	endproperty
	a_ack_vec: assert property (p_ack_vec) else $error("ack without vector");
	property p_ack_pulse;
		INT_ACK |=> !INT_ACK;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ro_err;
		s_ro_write |-> APB_RSP.pslverr;
	endproperty
	a_ro_err: assert property (p_ro_err) else $error("latch write not refused");
	property p_err_idle;
		!(APB_REQ.psel && APB_REQ.penable) |-> !APB_RSP.pslverr;
	endproperty
	a_err_idle: assert property (p_err_idle) else $error("error outside access");
	property p_ready;
		s_access |-> APB_RSP.pready;
	endproperty
	a_ready: assert property (p_ready) else $error("access not answered");
endmodule
bind program_sequencer program_sequencer_properties #(.STACK_DEPTH(STACK_DEPTH)) props_inst (
	.CLK(CLK), .SYS_RST(SYS_RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .PM_ADDR(PM_ADDR),
	.PM_RDATA(PM_RDATA), .INT_REQ(INT_REQ), .INT_ACK(INT_ACK), .CYCLE_PHASES(CYCLE_PHASES));

//--- verification/prog_memory_model.sv
// program memory model holding the test program
// assumes a read that follows the address within the instruction cycle
`timescale 1ns/10ps
module prog_memory_model
	import program_sequencer_pkg::*;
(
	// fetch port
	input  wire program_sequencer_pkg::pc_t   addr,
	output      program_sequencer_pkg::word_t rdata
);
	word_t mem [0:2047];
	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i] = 16'h0000;
		end
		mem[11'h000] = 16'h5F05;
		mem[11'h001] = 16'h50FF;
		mem[11'h002] = 16'h1010;
		mem[11'h004] = 16'h4000;
		mem[11'h010] = 16'h2020;
		mem[11'h011] = 16'h9000;
		mem[11'h012] = 16'h8000;
		mem[11'h013] = 16'h6001;
		mem[11'h014] = 16'h1000;
		mem[11'h015] = 16'h1115;
		mem[11'h020] = 16'h3000;
		mem[11'h115] = 16'h1115;
		mem[11'h130] = 16'h1130;
		// call chain that fills, then overflows, a two-deep stack
		mem[11'h140] = 16'h2150;
		mem[11'h150] = 16'h2160;
		mem[11'h160] = 16'h2170;
		mem[11'h170] = 16'h1170;
		mem[11'h180] = 16'h3000;
		mem[11'h704] = 16'h1234;
	end
	assign rdata = mem[addr];
endmodule

//--- verification/tb.sv
// self-checking bench for the program sequencer
// assumes the memory model and the checker bind are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
	import program_sequencer_pkg::*;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d, e; logic err;} row_t;
	logic        clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic        int_req = 1'h0;
	apb_req_t    req = '0;
	apb_rsp_t    rsp;
	pc_t         pm_addr;
	word_t       pm_rdata;
	logic        int_ack;
	phase_t      ph;
	int          n_fail = 0;
	int          compares = 0;
	int          n_tr = 0;
	pc_t         last = '0;
	pc_t         trace [16];
	logic [31:0] rd;
	logic        er;
	logic        seen;
	pc_t exp_tr [16] = '{11'h001, 11'h002, 11'h003, 11'h010, 11'h011, 11'h020, 11'h021,
		11'h011, 11'h012, 11'h013, 11'h704, 11'h014, 11'h015, 11'h016, 11'h115, 11'h116};
	row_t rows [10] = '{'{1'h0, OFS_ACC, 32'h0, 32'h34, 1'h0}, '{1'h0, OFS_TABLE_HIGH_LATCH, 32'h0, 32'h12, 1'h0},
		'{1'h1, OFS_TABLE_HIGH_LATCH, 32'hFF, 32'h0, 1'h1}, '{1'h0, OFS_TABLE_HIGH_LATCH, 32'h0, 32'h12, 1'h0},
		'{1'h1, OFS_ACC, 32'h0, 32'h0, 1'h1}, '{1'h0, OFS_ACC, 32'h0, 32'h34, 1'h0},
		'{1'h0, OFS_TPTR, 32'h0, 32'h4, 1'h0}, '{1'h0, OFS_STATUS, 32'h0, 32'h3, 1'h0},
		'{1'h0, OFS_CTRL, 32'h0, 32'h1, 1'h0}, '{1'h0, 8'h40, 32'h0, 32'h0, 1'h1}};
	program_sequencer #(.STACK_DEPTH(2)) program_sequencer_inst (.CLK(clk), .SYS_RST(sys_rst),
		.APB_REQ(req), .APB_RSP(rsp), .PM_ADDR(pm_addr), .PM_RDATA(pm_rdata),
		.INT_REQ(int_req), .INT_ACK(int_ack), .CYCLE_PHASES(ph));
	prog_memory_model prog_memory_model_inst (.addr(pm_addr), .rdata(pm_rdata));
	always #25 clk = ~clk;
	// keep only address changes, so dummy cycles need no exact count
	always @(posedge clk) begin
		if (!sys_rst && n_tr < 16 && pm_addr !== last) begin
			last = pm_addr;
			trace[n_tr] = pm_addr;
			n_tr++;
		end
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// entered just after a rising edge; zero wait is not assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'h1 && n < 16);
		if (rsp.pready !== 1'h1) n_fail++;
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic wait_addr(input pc_t a);
		for (int n = 0; n < 100 && pm_addr !== a; n++) @(posedge clk);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'h0;
		for (int n = 0; n < 400 && n_tr < 16; n++) @(posedge clk);
		for (int i = 0; i < 16; i++) `CHK("trace", exp_tr[i], trace[i])
		$display("test flow done");
		for (int i = 0; i < 10; i++) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) `CHK("prdata", rows[i].e, rd)
			`CHK("pslverr", rows[i].err, er)
		end
		$display("test registers done");
		apb(1'h1, OFS_PCL, 32'h30);
		wait_addr(11'h130);
		`CHK("pcl jump", 11'h130, pm_addr)
		$display("test page jump done");
		apb(1'h1, OFS_CTRL, 32'h3);
		int_req <= 1'h1;
		@(posedge clk);
		int_req <= 1'h0;
		for (int n = 0; n < 100 && int_ack !== 1'h1; n++) @(posedge clk);
		`CHK("int ack", 1'h1, int_ack)
		@(posedge clk);
		wait_addr(11'h130);
		`CHK("return addr", 11'h130, pm_addr)
		apb(1'h0, OFS_CTRL, 32'h0);
		`CHK("ie after return", 32'h3, rd)
		$display("test interrupt done");
		// three calls on a two-deep stack, then an interrupt that must wait for a pop
		apb(1'h1, OFS_PCL, 32'h40);
		wait_addr(11'h170);
		`CHK("call on full stack", 11'h170, pm_addr)
		int_req <= 1'h1;
		@(posedge clk);
		int_req <= 1'h0;
		seen = 1'h0;
		repeat (40) begin
			@(posedge clk);
			seen |= int_ack;
		end
		`CHK("ack held", 1'h0, seen)
		apb(1'h0, OFS_STATUS, 32'h0);
		`CHK("flag kept", 32'h13, rd)
		apb(1'h1, OFS_PCL, 32'h80);
		for (int n = 0; n < 100 && int_ack !== 1'h1; n++) @(posedge clk);
		`CHK("ack after pop", 1'h1, int_ack)
		wait_addr(11'h170);
		`CHK("back to loop", 11'h170, pm_addr)
		$display("test stack done");
		sys_rst <= 1'h1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'h0;
		`CHK("reset pc", 11'h000, pm_addr)
		apb(1'h0, OFS_ACC, 32'h0);
		`CHK("reset acc", 32'h0, rd)
		apb(1'h0, OFS_CTRL, 32'h0);
		`CHK("reset ctrl", 32'h1, rd)
		$display("test reset done");
		finish_test();
	end
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end
endmodule
